// ==== common/aoms_pkg.sv ====
// Package: states, carriers and timing constants for the amplifier mode selector
package aoms_pkg;

  typedef enum logic [2:0] {
    AOMS_OFF = 3'b000,
    AOMS_STANDBY = 3'b001,
    AOMS_MUTE = 3'b010,
    AOMS_OPERATE = 3'b011
  } aoms_mode_t;

  // Mode inputs after synchronising
  typedef struct packed {
    logic enable;
    logic mute_select;
    logic bus_mode;
  } aoms_pins_t;

  // Host-programmed control bits
  typedef struct packed {
    logic ctrl_byte1_bit0;
    logic ctrl_byte2_bit0;
  } aoms_ctrl_t;

  localparam int AOMS_CLK_HZ = 100000000;
  localparam int AOMS_FADE_US = 10;
  localparam int AOMS_FADE_CYCLES = AOMS_FADE_US * (AOMS_CLK_HZ / 1000000);
  localparam int AOMS_FADE_W = 12;
  localparam logic [AOMS_FADE_W-1:0] AOMS_FADE_MAX = AOMS_FADE_W'(AOMS_FADE_CYCLES);
  localparam logic [AOMS_FADE_W-1:0] AOMS_FADE_ZERO = 12'h000;
  localparam int AOMS_SYNC_STAGES = 3;
  localparam int AOMS_NUM_INPUTS = 3;
  localparam int AOMS_PWM_W = 8;
  localparam logic [AOMS_PWM_W-1:0] AOMS_PWM_HALF = 8'h80;
  localparam logic [1:0] AOMS_CTRL_RESET = 2'h0;

  localparam logic [3:0] AOMS_ADDR_CTRL = 4'h0;
  localparam logic [3:0] AOMS_ADDR_STATUS = 4'h4;
  localparam logic [3:0] AOMS_ADDR_FADE = 4'h8;
  localparam logic [1:0] AOMS_CTRL_B1_POS = 2'h0;
  localparam logic [1:0] AOMS_CTRL_B2_POS = 2'h1;

endpackage : aoms_pkg

// ==== hdl/aoms_sync.sv ====
// Three-stage synchroniser with agreement filter for asynchronous pins
module aoms_sync
  import aoms_pkg::*;
#(
  parameter int WIDTH = AOMS_NUM_INPUTS
) (
  input wire logic CLK, // system clock
  input wire logic RESET, // synchronous reset, active high
  input wire logic CE, // clock enable
  input wire logic [WIDTH-1:0] D, // raw pin levels
  output logic [WIDTH-1:0] Q // filtered levels
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      // s1 feeds only s2 to keep metastability contained
      always_ff @(posedge CLK) begin
        if (RESET) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          Q[i] <= 1'b0;
        end else if (CE) begin
          s1 <= D[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            Q[i] <= s3;
          end
        end
      end
    end
  endgenerate

endmodule : aoms_sync

// ==== hdl/aoms_top.sv ====
// Operating-mode selector for a two-channel class-D amplifier
// What this block does
// - Enable pin high enables the device in either control style.
// - Enable low: fully off, lowest current, bus commands ignored.
// - Strap through resistor to ground selects host-bus control.
// - Strap shorted to ground selects pin-only control.
// - Bus control with enable high idles until host configures it.
// - Pin-only defaults to mute: stages idle at half duty, audio suppressed.
// - Mute-select chooses mute or unmute with gradual fade ramps.
// - Pin-only: enable moves between off and mute; mute-select low stays muted.
// - Bus control: enable moves between off (default) and standby.
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
module aoms_top
  import aoms_pkg::*;
(
  input wire logic CLK, // system clock, 100 MHz
  input wire logic RESET, // synchronous reset, active high
  input wire logic CE, // clock enable, freezes all state when low
  input wire logic ENABLE_PIN, // enable pin, asynchronous
  input wire logic MUTE_SELECT_PIN, // mute-select pin, asynchronous
  input wire logic ADDRESS_STRAP_PIN, // high: resistor fitted, low: shorted
  input wire logic [3:0] AVS_ADDRESS, // Avalon byte address
  input wire logic AVS_READ, // Avalon read
  input wire logic AVS_WRITE, // Avalon write
  input wire logic [31:0] AVS_WRITEDATA, // Avalon write data
  input wire logic [3:0] AVS_BYTEENABLE, // Avalon byte enables
  output logic [31:0] AVS_READDATA, // Avalon read data
  output logic AVS_WAITREQUEST, // Avalon wait request
  output logic [2:0] MODE, // current mode code
  output logic STAGE_ACTIVE, // power stages switching
  output logic AUDIO_PASS, // audio reaches outputs
  output logic [AOMS_FADE_W-1:0] GAIN, // fade gain level
  output logic [AOMS_PWM_W-1:0] PWM_IDLE_DUTY // duty used while muted
);

  aoms_pins_t pins;
  aoms_ctrl_t ctrl;
  aoms_mode_t mode;
  aoms_mode_t next_mode;
  logic bus_mode;
  logic strap_taken;
  logic [AOMS_FADE_W-1:0] fade;
  logic [AOMS_FADE_W-1:0] next_fade;
  logic ack;
  logic [31:0] read_word;

  aoms_sync #(
    .WIDTH(AOMS_NUM_INPUTS)
  ) u_sync (
    .CLK(CLK),
    .RESET(RESET),
    .CE(CE),
    .D({ENABLE_PIN, MUTE_SELECT_PIN, ADDRESS_STRAP_PIN}),
    .Q(pins)
  );

  // Strap caught each time enable rises; enable going low re-arms the capture.
  // Latching keeps a noisy strap from flipping control style mid-play.
  wire strap_capture = pins.enable && !strap_taken;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      strap_taken <= 1'b0;
    end else if (CE) begin
      if (!pins.enable) begin
        strap_taken <= 1'b0;
      end else begin
        strap_taken <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      bus_mode <= 1'b0;
    end else if (CE) begin
      if (strap_capture) begin
        bus_mode <= pins.bus_mode;
      end
    end
  end

  // Bus access: one wait cycle, then acknowledge
  wire bus_req = AVS_READ || AVS_WRITE;
  assign AVS_WAITREQUEST = bus_req && !ack;
  wire take_write = AVS_WRITE && ack && CE;
  wire hit_ctrl = AVS_ADDRESS == AOMS_ADDR_CTRL;
  wire hit_status = AVS_ADDRESS == AOMS_ADDR_STATUS;
  wire hit_fade = AVS_ADDRESS == AOMS_ADDR_FADE;
  // Commands are dropped while off or in pin-only control
  wire ctrl_accept = take_write && hit_ctrl && AVS_BYTEENABLE[0] &&
                     strap_taken && bus_mode;
  wire write_b1 = AVS_WRITEDATA[AOMS_CTRL_B1_POS];
  wire write_b2 = AVS_WRITEDATA[AOMS_CTRL_B2_POS];

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ack <= 1'b0;
    end else if (CE) begin
      ack <= bus_req && !ack;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl <= AOMS_CTRL_RESET;
    end else if (CE) begin
      if (!pins.enable) begin
        ctrl <= AOMS_CTRL_RESET;
      end else if (ctrl_accept) begin
        ctrl.ctrl_byte1_bit0 <= write_b1;
        ctrl.ctrl_byte2_bit0 <= write_b2;
      end
    end
  end

  wire [31:0] ctrl_word = {30'h00000000, ctrl.ctrl_byte2_bit0, ctrl.ctrl_byte1_bit0};
  wire [31:0] status_word = {27'h0000000, bus_mode, pins.enable, mode};
  wire [31:0] fade_word = {20'h00000, fade};
  assign read_word = hit_ctrl ? ctrl_word :
                     hit_status ? status_word :
                     hit_fade ? fade_word : 32'h00000000;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      AVS_READDATA <= 32'h00000000;
    end else if (CE) begin
      if (AVS_READ && !ack) begin
        AVS_READDATA <= read_word;
      end
    end
  end

  // Bus-control table, first matching row wins
  wire want_standby = !ctrl.ctrl_byte1_bit0;
  wire want_operate = pins.mute_select && !ctrl.ctrl_byte2_bit0;
  wire want_mute = !pins.mute_select && ctrl.ctrl_byte2_bit0;

  // Mode decision
  always_comb begin
    next_mode = AOMS_OFF;
    if (pins.enable && strap_taken) begin
      if (bus_mode) begin
        if (want_standby) begin
          next_mode = AOMS_STANDBY;
        end else if (want_operate) begin
          next_mode = AOMS_OPERATE;
        end else if (want_mute) begin
          next_mode = AOMS_MUTE;
        end else begin
          // Combinations outside the table hold the quiet choice
          next_mode = AOMS_STANDBY;
        end
      end else begin
        // Host raises both pins to play
        next_mode = pins.mute_select ? AOMS_OPERATE : AOMS_MUTE;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      mode <= AOMS_OFF;
    end else if (CE) begin
      mode <= next_mode;
    end
  end

  // Fade ramp stands in for the external time-constant capacitor
  always_comb begin
    next_fade = fade;
    unique case (mode)
      AOMS_OPERATE: begin
        if (fade != AOMS_FADE_MAX) begin
          next_fade = fade + 12'h001;
        end
      end
      AOMS_MUTE, AOMS_STANDBY: begin
        if (fade != AOMS_FADE_ZERO) begin
          next_fade = fade - 12'h001;
        end
      end
      AOMS_OFF: begin
        next_fade = AOMS_FADE_ZERO;
      end
      default: begin
        next_fade = AOMS_FADE_ZERO;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      fade <= AOMS_FADE_ZERO;
    end else if (CE) begin
      fade <= next_fade;
    end
  end

  wire stages_on = (mode == AOMS_MUTE) || (mode == AOMS_OPERATE);
  wire audio_on = fade != AOMS_FADE_ZERO;
  wire [AOMS_PWM_W-1:0] next_duty = stages_on ? AOMS_PWM_HALF : 8'h00;

  // Outputs registered so the pins never glitch while the mode settles;
  // they trail the internal state by one cycle.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      MODE <= AOMS_OFF;
    end else if (CE) begin
      MODE <= mode;
    end
  end

  // Stages keep switching in mute so the outputs stay biased, no pop
  always_ff @(posedge CLK) begin
    if (RESET) begin
      STAGE_ACTIVE <= 1'b0;
    end else if (CE) begin
      STAGE_ACTIVE <= stages_on;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      AUDIO_PASS <= 1'b0;
    end else if (CE) begin
      AUDIO_PASS <= audio_on;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      GAIN <= AOMS_FADE_ZERO;
    end else if (CE) begin
      GAIN <= fade;
    end
  end

  // Half duty gives zero average output while muted
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PWM_IDLE_DUTY <= 8'h00;
    end else if (CE) begin
      PWM_IDLE_DUTY <= next_duty;
    end
  end

endmodule : aoms_top

// ==== test/aoms_top_props.sv ====
// Checker: port properties of the mode selector
module aoms_top_props
  import aoms_pkg::*;
(
  input wire logic CLK, // clock
  input wire logic RESET, // reset
  input wire logic ENABLE_PIN, // enable
  input wire logic MUTE_SELECT_PIN, // mute select
  input wire logic ADDRESS_STRAP_PIN, // strap
  input wire logic AVS_READ, // read
  input wire logic AVS_WAITREQUEST, // wait
  input wire logic [2:0] MODE, // mode
  input wire logic STAGE_ACTIVE, // stages on
  input wire logic AUDIO_PASS, // audio on
  input wire logic [AOMS_FADE_W-1:0] GAIN, // fade
  input wire logic [AOMS_PWM_W-1:0] PWM_IDLE_DUTY // duty
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RESET);
  off_when_low_a:
    assert property (!ENABLE_PIN [*8] |=> MODE == 3'h0)
    else $error("mode not off");
  pin_operate_a:
    assert property ((ENABLE_PIN && MUTE_SELECT_PIN && !ADDRESS_STRAP_PIN) [*8]
    |=> MODE == 3'h3) else $error("pin mode not operate");
  pin_mute_a:
    assert property ((ENABLE_PIN && !MUTE_SELECT_PIN && !ADDRESS_STRAP_PIN) [*8]
    |=> MODE == 3'h2) else $error("pin mode not mute");
  stage_mode_a:
    assert property (STAGE_ACTIVE == MODE[1])
    else $error("stage flag wrong");
  idle_duty_a:
    assert property (PWM_IDLE_DUTY == (STAGE_ACTIVE ? AOMS_PWM_HALF : 8'h00))
    else $error("idle duty wrong");
  audio_gain_a:
    assert property (AUDIO_PASS == (GAIN != 12'h000))
    else $error("audio flag wrong");
  gain_cap_a:
    assert property (GAIN <= AOMS_FADE_MAX)
    else $error("gain above max");
  fade_step_a:
    assert property (MODE != 3'h0 && $past(MODE) != 3'h0 |->
    GAIN <= $past(GAIN) + 12'h001 && $past(GAIN) <= GAIN + 12'h001)
    else $error("gain jumped");
  bus_wait_a:
    assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("wait cycle wrong");
endmodule : aoms_top_props
bind aoms_top aoms_top_props p (.*);

// ==== test/aoms_host.sv ====
// Host model: mode pins and Avalon master
module aoms_host
  import aoms_pkg::*;
(
  input wire logic CLK, // clock
  input wire logic WAITREQ, // wait
  input wire logic [31:0] RDATA, // read data
  output logic EN = 1'b0, // enable
  output logic MSEL = 1'b0, // mute select
  output logic STRAP = 1'b0, // strap
  output logic [3:0] ADDR = 4'h0, // address
  output logic RD = 1'b0, // read
  output logic WR = 1'b0, // write
  output logic [31:0] WDATA = 32'h0 // write data
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q, output bit ok);
    ok = 1'b0;
    q = 32'h00000000;
    @(posedge CLK);
    RD <= !w;
    WR <= w;
    ADDR <= a;
    WDATA <= d;
    // Sample the answer at the rising edge itself, before the slave updates
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge CLK);
      if (!WAITREQ) begin
        ok = 1'b1;
        q = RDATA;
      end
    end
    RD <= 1'b0;
    WR <= 1'b0;
    WDATA <= ~d;
  endtask : xfer
endmodule : aoms_host

// ==== test/tb_aoms_top.sv ====
// Bench: pin and register sequences for the mode selector
module tb_aoms_top
  import aoms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic en, msel, strap, rd, wr, wreq, stage, pass;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [2:0] mode;
  logic [11:0] gain;
  logic [11:0] g;
  logic ce = 1'b1;
  logic [7:0] duty;
  int err_total = 0;
  int checks_done = 0;
  bit ok;
  always #5 CLK = ~CLK;
  aoms_host h (.CLK(CLK), .WAITREQ(wreq), .RDATA(rdata), .EN(en), .MSEL(msel),
    .STRAP(strap), .ADDR(addr), .RD(rd), .WR(wr), .WDATA(wdata));
  aoms_top uut (.CLK(CLK), .RESET(RESET), .CE(ce), .ENABLE_PIN(en), .MUTE_SELECT_PIN(msel),
    .ADDRESS_STRAP_PIN(strap), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .MODE(mode), .STAGE_ACTIVE(stage), .AUDIO_PASS(pass),
    .GAIN(gain), .PWM_IDLE_DUTY(duty));
  task automatic end_sim;
    if (err_total == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic pins(input logic e, input logic m, input logic s);
    @(posedge CLK);
    h.EN <= e;
    h.MSEL <= m;
    h.STRAP <= s;
  endtask : pins
  // Pins pass a synchroniser, so allow a bounded settle
  task automatic wm(input logic [2:0] m);
    for (int i = 0; i < 30 && mode !== m; i++) @(posedge CLK);
    chk({29'h0, mode}, {29'h0, m});
    if (mode !== m) end_sim();
  endtask : wm
  task automatic rw(input logic w, input logic [3:0] a, input logic [31:0] d);
    h.xfer(w, a, d, q, ok);
    chk({31'h0, ok}, 32'h1);
    if (!ok) end_sim();
  endtask : rw
  initial begin
    repeat (8) @(posedge CLK);
    RESET <= 1'b0;
    chk({29'h0, mode}, 32'h0);
    pins(1'b1, 1'b0, 1'b0);
    wm(AOMS_MUTE);
    chk({24'h0, duty}, 32'h80);
    chk({31'h0, pass}, 32'h0);
    chk({31'h0, stage}, 32'h1);
    pins(1'b1, 1'b1, 1'b0);
    wm(AOMS_OPERATE);
    repeat (20) @(posedge CLK);
    ce <= 1'b0;
    @(posedge CLK);
    g = gain;
    repeat (50) @(posedge CLK);
    chk({20'h0, gain}, {20'h0, g});
    ce <= 1'b1;
    repeat (1100) @(posedge CLK);
    chk({20'h0, gain}, {20'h0, AOMS_FADE_MAX});
    chk({31'h0, pass}, 32'h1);
    pins(1'b1, 1'b0, 1'b0);
    repeat (1100) @(posedge CLK);
    chk({20'h0, gain}, 32'h0);
    pins(1'b0, 1'b1, 1'b1);
    wm(AOMS_OFF);
    chk({31'h0, stage}, 32'h0);
    chk({24'h0, duty}, 32'h0);
    rw(1'b1, AOMS_ADDR_CTRL, 32'h3);
    pins(1'b1, 1'b0, 1'b1);
    wm(AOMS_STANDBY);
    rw(1'b0, AOMS_ADDR_CTRL, 32'h0);
    chk(q, 32'h0);
    rw(1'b1, AOMS_ADDR_CTRL, 32'h3);
    wm(AOMS_MUTE);
    pins(1'b1, 1'b1, 1'b1);
    wm(AOMS_STANDBY);
    rw(1'b1, AOMS_ADDR_CTRL, 32'h1);
    wm(AOMS_OPERATE);
    rw(1'b0, AOMS_ADDR_STATUS, 32'h0);
    chk(q, 32'h1B);
    rw(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    rw(1'b1, AOMS_ADDR_CTRL, 32'h0);
    wm(AOMS_STANDBY);
    end_sim();
  end
endmodule : tb_aoms_top
